// file: rtl/pec_ms_timer.sv
// Purpose: millisecond tick divider for the pin enable control block
// Assumes: one clock, asynchronous active-low reset
// Notes: tick is a one-cycle enable pulse

`timescale 1ns/10ps
module pec_ms_timer #(
	parameter int DIVIDE = 50000
) (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// tick out
	output logic tick
);
	logic [31:0] count;
	logic [31:0] next_count;

	// wrap the divider every DIVIDE cycles
	always_comb begin
		if (count == 32'(DIVIDE - 1)) begin
			next_count = 32'h0;
		end else begin
			next_count = count + 32'h1;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			count <= 32'h0;
		end else begin
			count <= next_count;
		end
	end

	assign tick = (count == 32'(DIVIDE - 1));
endmodule : pec_ms_timer

// file: rtl/pec_pin_enable_control.sv
// Purpose: pin level start, hold and enable logic of a multi-rail power unit
// Assumes: pins synchronous to clock; millisecond timing from a divider
// Notes: straps captured once after reset release

`timescale 1ns/10ps
// Contract
// - sub role: buck 2 on when its pin or its enable bit is high
// - main role: shared pin is the supply hold input
// - role strap low selects sub role, high selects main role
// - default strap high selects setup 1, low selects setup 2
// - with control bit 2 clear, scaling pin high picks set one else set two
// - sub role: enable high turns outputs on, low returns to standby
// - main role: power request starts up after 30 ms debounce
// - ldo 3 on when its pin or its enable bit is high
// - a buck that is off pulls its feedback node down
// - sub role: reset released 30 ms after enable high, asserted on low
// - main role: reset released 60 ms after request, asserted 30 ms after hold low
// - main role: shutdown when hold and request both low 30 ms
module pec_pin_enable_control #(
	parameter int TICK_DIV = pec_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// straps
	input wire logic roleStrap,
	input wire logic default_setup_strap,
	// host pins
	input wire pec_pkg::pec_pins_t pins,
	// register port
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	// outputs
	output pec_pkg::pec_rails_t rails,
	output logic setupTwo,
	output logic resetOut_n
);
	import pec_pkg::*;

	logic tick;
	logic strapsTaken, mainRole, setupTwoR;
	logic next_strapsTaken, next_mainRole, next_setupTwoR;
	logic [7:0] ctrlReg, enableReg, next_ctrlReg, next_enableReg;
	pec_state_t state, next_state;
	logic [6:0] msCount, next_msCount;
	logic [6:0] offCount, next_offCount;
	logic rstOut, next_rstOut;
	logic outputsOn;
	logic holdIn, reqIn;
	logic [7:0] next_regRdData;

	pec_ms_timer #(.DIVIDE(TICK_DIV)) u_timer (
		.clock(clock),
		.nrst(nrst),
		.tick(tick)
	);

	// strap capture on the first clock after release
	always_comb begin
		next_strapsTaken = 1'b1;
		next_mainRole = strapsTaken ? mainRole : roleStrap;
		next_setupTwoR = strapsTaken ? setupTwoR : !default_setup_strap;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			strapsTaken <= 1'b0;
			mainRole <= 1'b0;
			setupTwoR <= 1'b0;
		end else begin
			strapsTaken <= next_strapsTaken;
			mainRole <= next_mainRole;
			setupTwoR <= next_setupTwoR;
		end
	end

	assign holdIn = mainRole && pins.sharedPin;
	assign reqIn = pins.enableOrRequest;

	// register writes and read data
	always_comb begin
		next_ctrlReg = ctrlReg;
		next_enableReg = enableReg;
		next_regRdData = 8'h00;
		if (regWrite && regAddr == REG_CTRL) begin
			next_ctrlReg = regWrData;
		end
		if (regWrite && regAddr == REG_ENABLE) begin
			next_enableReg = regWrData;
		end
		if (regRead) begin
			unique case (regAddr)
				REG_CTRL: next_regRdData = ctrlReg;
				REG_ENABLE: next_regRdData = enableReg;
				REG_STATUS: next_regRdData = {2'h0, state, setupTwoR, mainRole, rstOut};
				default: next_regRdData = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ctrlReg <= CTRL_RESET;
			enableReg <= ENABLE_RESET;
			regRdData <= 8'h00;
		end else begin
			ctrlReg <= next_ctrlReg;
			enableReg <= next_enableReg;
			regRdData <= next_regRdData;
		end
	end

	// sequencer: counts whole milliseconds on the tick
	always_comb begin
		next_state = state;
		next_msCount = msCount;
		next_rstOut = rstOut;
		next_offCount = offCount;
		if (!strapsTaken) begin
			next_state = PEC_OFF;
		end else if (!mainRole) begin
			unique case (state)
				PEC_OFF, PEC_DEBOUNCE, PEC_HOLDLOSS: begin
					next_rstOut = 1'b0;
					next_msCount = 7'h00;
					next_state = reqIn ? PEC_STARTING : PEC_OFF;
				end
				PEC_STARTING, PEC_ON: begin
					if (!reqIn) begin
						next_state = PEC_OFF;
						next_rstOut = 1'b0;
						next_msCount = 7'h00;
					end else if (state == PEC_STARTING && tick) begin
						next_msCount = msCount + 7'h01;
						if (msCount == 7'(RESET_RELEASE_MS - 1)) begin
							next_state = PEC_ON;
							next_rstOut = 1'b1;
						end
					end
				end
				default: next_state = PEC_OFF;
			endcase
		end else begin
			unique case (state)
				PEC_OFF: begin
					next_offCount = 7'h00;
					next_rstOut = 1'b0;
					next_msCount = 7'h00;
					if (reqIn) begin
						next_state = PEC_DEBOUNCE;
					end
				end
				PEC_DEBOUNCE: begin
					if (!reqIn) begin
						next_state = PEC_OFF;
						next_msCount = 7'h00;
					end else if (tick) begin
						next_msCount = msCount + 7'h01;
						if (msCount == 7'(DEBOUNCE_MS - 1)) begin
							next_state = PEC_STARTING;
						end
					end
				end
				PEC_STARTING: begin
					if (tick) begin
						next_msCount = msCount + 7'h01;
						if (msCount == 7'(DEBOUNCE_MS + RESET_RELEASE_MS - 1)) begin
							next_state = PEC_ON;
							next_rstOut = 1'b1;
							next_msCount = 7'h00;
						end
					end
				end
				PEC_ON, PEC_HOLDLOSS: begin
					// separate counts, so a request held high cannot mask the loss of hold
					if (holdIn) begin
						next_msCount = 7'h00;
					end else if (tick) begin
						next_msCount = msCount + 7'h01;
					end
					if (holdIn || reqIn) begin
						next_offCount = 7'h00;
					end else if (tick) begin
						next_offCount = offCount + 7'h01;
					end
					next_state = holdIn ? PEC_ON : PEC_HOLDLOSS;
					if (!holdIn && tick && msCount == 7'(HOLD_LOSS_MS - 1)) begin
						next_rstOut = 1'b0;
					end
					if (!holdIn && !reqIn && tick && offCount == 7'(SHUTDOWN_MS - 1)) begin
						next_state = PEC_OFF;
						next_msCount = 7'h00;
						next_offCount = 7'h00;
					end
				end
				default: next_state = PEC_OFF;
			endcase
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state <= PEC_OFF;
			msCount <= 7'h00;
			offCount <= 7'h00;
			rstOut <= 1'b0;
		end else begin
			state <= next_state;
			msCount <= next_msCount;
			offCount <= next_offCount;
			rstOut <= next_rstOut;
		end
	end

	assign outputsOn = (state == PEC_STARTING) || (state == PEC_ON) || (state == PEC_HOLDLOSS);

	// regulator controls
	pec_rails_t next_rails;
	always_comb begin
		next_rails.buck1On = outputsOn && enableReg[EN_BUCK1_BIT];
		next_rails.buck2On = outputsOn && (enableReg[EN_BUCK2_BIT]
			|| (!mainRole && pins.sharedPin));
		next_rails.ldo3On = outputsOn && (enableReg[EN_LDO3_BIT] || pins.ldo3PinEnable);
		next_rails.firstBuckFeedbackPull = !next_rails.buck1On;
		next_rails.secondBuckFeedbackPull = !next_rails.buck2On;
		// host keeps the pin valid while bucks run
		next_rails.useVoltageSetTwo = ctrlReg[CTRL_DVS_IGNORE_BIT] ? 1'b0
			: !pins.voltageScalingPin;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rails <= RAILS_RESET;
		end else begin
			rails <= next_rails;
		end
	end

	assign setupTwo = setupTwoR;
	assign resetOut_n = rstOut;

	// assertions
	property p_buck2_or;
		@(posedge clock) disable iff (!nrst)
		(outputsOn && !mainRole && pins.sharedPin) |=> rails.buck2On;
	endproperty
	a_buck2_or: assert property (p_buck2_or) else $error("buck2 pin ignored");
	property p_hold_no_buck;
		@(posedge clock) disable iff (!nrst)
		(mainRole && !enableReg[EN_BUCK2_BIT]) |=> !rails.buck2On;
	endproperty
	a_hold_no_buck: assert property (p_hold_no_buck) else $error("hold pin enabled buck2");
	property p_strap_stable;
		@(posedge clock) disable iff (!nrst)
		strapsTaken |=> $stable(mainRole) && $stable(setupTwoR);
	endproperty
	a_strap_stable: assert property (p_strap_stable) else $error("strap changed");
	property p_setup;
		@(posedge clock) disable iff (!nrst)
		$rose(strapsTaken) |-> (setupTwoR == !$past(default_setup_strap)) && (mainRole == $past(roleStrap));
	endproperty
	a_setup: assert property (p_setup) else $error("strap capture wrong");
	property p_dvs;
		@(posedge clock) disable iff (!nrst)
		!ctrlReg[CTRL_DVS_IGNORE_BIT] |=> rails.useVoltageSetTwo == !$past(pins.voltageScalingPin);
	endproperty
	a_dvs: assert property (p_dvs) else $error("voltage set wrong");
	property p_sub_off;
		@(posedge clock) disable iff (!nrst)
		(strapsTaken && !mainRole && !reqIn) |=> (state == PEC_OFF) && !rstOut;
	endproperty
	a_sub_off: assert property (p_sub_off) else $error("enable low not standby");
	property p_debounce_abort;
		@(posedge clock) disable iff (!nrst)
		(state == PEC_DEBOUNCE && !reqIn) |=> state == PEC_OFF && msCount == 7'h00;
	endproperty
	a_debounce_abort: assert property (p_debounce_abort) else $error("debounce not abandoned");
	property p_no_early_start;
		@(posedge clock) disable iff (!nrst)
		(state == PEC_DEBOUNCE && msCount < 7'(DEBOUNCE_MS - 1)) |=> state != PEC_STARTING;
	endproperty
	a_no_early_start: assert property (p_no_early_start) else $error("start before debounce");
	property p_ldo3;
		@(posedge clock) disable iff (!nrst)
		(outputsOn && pins.ldo3PinEnable) |=> rails.ldo3On;
	endproperty
	a_ldo3: assert property (p_ldo3) else $error("ldo3 pin ignored");
	property p_pull;
		@(posedge clock) disable iff (!nrst)
		!(rails.buck1On && rails.firstBuckFeedbackPull) && !(rails.buck2On && rails.secondBuckFeedbackPull);
	endproperty
	a_pull: assert property (p_pull) else $error("pull-down while on");
	property p_main_release;
		@(posedge clock) disable iff (!nrst)
		(mainRole && $rose(rstOut)) |-> $past(state) == PEC_STARTING;
	endproperty
	a_main_release: assert property (p_main_release) else $error("reset release out of order");
	property p_shutdown;
		@(posedge clock) disable iff (!nrst)
		(mainRole && $past(state) == PEC_HOLDLOSS && state == PEC_OFF) |-> !$past(reqIn) && !$past(holdIn);
	endproperty
	a_shutdown: assert property (p_shutdown) else $error("shutdown with input high");
	c_sub_on: cover property (@(posedge clock) disable iff (!nrst) !mainRole && $rose(rstOut));
	c_main_on: cover property (@(posedge clock) disable iff (!nrst) mainRole && $rose(rstOut));
	c_abort: cover property (@(posedge clock) disable iff (!nrst) state == PEC_DEBOUNCE && !reqIn);
	c_shut: cover property (@(posedge clock) disable iff (!nrst) $past(state) == PEC_HOLDLOSS && state == PEC_OFF);
endmodule : pec_pin_enable_control

// file: rtl/pec_pkg.sv
// Purpose: shared constants and types for the pin enable control block
// Assumes: 50 MHz clock, millisecond timing from a one-cycle tick
// Notes: register bus is a plain strobe port

package pec_pkg;
	// clock and timing
	localparam int CLK_HZ = 50000000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
	localparam int DEBOUNCE_MS = 30;
	localparam int RESET_RELEASE_MS = 30;
	localparam int HOLD_LOSS_MS = 30;
	localparam int SHUTDOWN_MS = 30;

	// register offsets (word addresses on the plain port)
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_ENABLE = 4'h1;
	localparam logic [3:0] REG_STATUS = 4'h2;

	// field positions
	localparam int CTRL_DVS_IGNORE_BIT = 2;
	localparam int EN_BUCK1_BIT = 0;
	localparam int EN_BUCK2_BIT = 1;
	localparam int EN_LDO3_BIT = 2;

	// reset values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] ENABLE_RESET = 8'h00;

	typedef enum logic [2:0] {
		PEC_OFF = 3'b000,
		PEC_DEBOUNCE = 3'b001,
		PEC_STARTING = 3'b011,
		PEC_ON = 3'b010,
		PEC_HOLDLOSS = 3'b110
	} pec_state_t;

	// pins driven by the host
	typedef struct packed {
		logic enableOrRequest;
		logic sharedPin;
		logic ldo3PinEnable;
		logic voltageScalingPin;
	} pec_pins_t;

	// regulator controls leaving the block
	typedef struct packed {
		logic buck1On;
		logic buck2On;
		logic ldo3On;
		logic firstBuckFeedbackPull;
		logic secondBuckFeedbackPull;
		logic useVoltageSetTwo;
	} pec_rails_t;

	// rails after reset: every regulator off, both feedback pulls on
	localparam pec_rails_t RAILS_RESET = 6'h06;
endpackage : pec_pkg

// file: tb/pec_host_model.sv
// Purpose: host model that drives the pins of the pin enable control block
// Assumes: host pins change just after a rising clock edge
// Notes: the scaling pin is never left floating

`timescale 1ns/10ps
module pec_host_model (
	// clock
	input wire logic clock,
	// host intent
	input wire logic wantOn,
	input wire logic holdUp,
	input wire logic ldoPin,
	input wire logic scaleHigh,
	// pins to the device
	output pec_pkg::pec_pins_t pins
);
	import pec_pkg::*;
	// register the host intent onto the pins
	always_ff @(posedge clock) begin
		pins.enableOrRequest <= wantOn;
		pins.sharedPin <= holdUp;
		pins.ldo3PinEnable <= ldoPin;
		pins.voltageScalingPin <= (scaleHigh === 1'b1); // always a valid level
	end
endmodule : pec_host_model

// file: tb/testbench.sv
// Purpose: self-checking bench for the pin enable control block
// Assumes: tick divider shortened to 4 cycles, so 1 ms is 4 clocks
// Notes: checks leave at least one tick of slack around each ms count

`timescale 1ns/10ps
module testbench;
	import pec_pkg::*;
	localparam int TD = 4;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic roleStrap = 1'b0;
	logic setupStrap = 1'b1;
	logic wantOn = 1'b0;
	logic holdUp = 1'b0;
	logic ldoPin = 1'b0;
	logic scaleHigh = 1'b1;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWrData = 8'h00;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [7:0] regRdData;
	logic [7:0] rd;
	pec_pins_t pins;
	pec_rails_t rails;
	logic setupTwo;
	logic resetOut_n;
	int failures = 0;
	int comparisons = 0;

	// 50 MHz clock
	always #10 clock = ~clock;

	pec_host_model i_host (.clock(clock), .wantOn(wantOn), .holdUp(holdUp), .ldoPin(ldoPin),
		.scaleHigh(scaleHigh), .pins(pins));

	pec_pin_enable_control #(.TICK_DIV(TD)) i_dut (.clock(clock), .nrst(nrst), .roleStrap(roleStrap),
		.default_setup_strap(setupStrap), .pins(pins), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .rails(rails),
		.setupTwo(setupTwo), .resetOut_n(resetOut_n));

	// compare and count
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk

	// wait whole ms ticks, then let the edge settle
	task automatic ticks(input int n);
		repeat (n * TD) @(posedge clock);
		#1;
	endtask : ticks

	// host pin intent
	task automatic drive(input logic on, input logic hold, input logic ldo, input logic scale);
		@(posedge clock);
		wantOn <= on;
		holdUp <= hold;
		ldoPin <= ldo;
		scaleHigh <= scale;
	endtask : drive

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask : wr

	// read data stands in the cycle after the strobe
	task automatic rdreg(input logic [3:0] a);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		#1;
		rd = regRdData;
	endtask : rdreg

	// reset with given straps held for 21 cycles
	task automatic rst(input logic role, input logic setup);
		drive(1'b0, 1'b0, 1'b0, 1'b1);
		nrst <= 1'b0;
		roleStrap <= role;
		setupStrap <= setup;
		repeat (20) @(posedge clock);
		#1;
		chk({2'b00, rails}, 8'h06);
		@(posedge clock);
		nrst <= 1'b1;
		ticks(1);
	endtask : rst

	task automatic sub_role_test;
		rst(1'b0, 1'b1);
		chk({7'h00, setupTwo}, 8'h00);
		rdreg(REG_CTRL);
		chk(rd, CTRL_RESET);
		rdreg(REG_ENABLE);
		chk(rd, ENABLE_RESET);
		rdreg(REG_STATUS);
		chk(rd & 8'h02, 8'h00);
		wr(4'hF, 8'hFF);
		rdreg(4'hF);
		chk(rd, 8'h00);
		wr(REG_ENABLE, 8'h05);
		drive(1'b1, 1'b0, 1'b0, 1'b1);
		ticks(2);
		chk({2'b00, rails} & 8'h3E, 8'h2A);
		ticks(25);
		chk({7'h00, resetOut_n}, 8'h00);
		ticks(5);
		chk({7'h00, resetOut_n}, 8'h01);
		drive(1'b1, 1'b1, 1'b0, 1'b1);
		ticks(1);
		chk({2'b00, rails}, 8'h38);
		drive(1'b1, 1'b1, 1'b0, 1'b0);
		ticks(1);
		chk({2'b00, rails}, 8'h39);
		wr(REG_CTRL, 8'h04);
		ticks(1);
		chk({2'b00, rails}, 8'h38);
		wr(REG_ENABLE, 8'h01);
		drive(1'b1, 1'b0, 1'b1, 1'b1);
		ticks(1);
		chk({2'b00, rails} & 8'h3E, 8'h2A);
		drive(1'b0, 1'b0, 1'b1, 1'b1);
		ticks(1);
		chk({7'h00, resetOut_n}, 8'h00);
		chk({2'b00, rails} & 8'h3E, 8'h06);
	endtask : sub_role_test

	task automatic main_role_test;
		rst(1'b1, 1'b0);
		@(posedge clock);
		roleStrap <= 1'b0;
		setupStrap <= 1'b1;
		ticks(1);
		chk({7'h00, setupTwo}, 8'h01);
		rdreg(REG_STATUS);
		chk(rd & 8'h02, 8'h02);
		wr(REG_ENABLE, 8'h01);
		drive(1'b1, 1'b1, 1'b0, 1'b1);
		ticks(10);
		drive(1'b0, 1'b1, 1'b0, 1'b1);
		ticks(2);
		drive(1'b1, 1'b1, 1'b0, 1'b1);
		ticks(28);
		chk({2'b00, rails} & 8'h3E, 8'h06);
		ticks(4);
		chk({2'b00, rails} & 8'h3E, 8'h22);
		ticks(25);
		chk({7'h00, resetOut_n}, 8'h00);
		ticks(6);
		chk({7'h00, resetOut_n}, 8'h01);
		drive(1'b0, 1'b1, 1'b0, 1'b1);
		ticks(35);
		chk({2'b00, rails} & 8'h3E, 8'h22);
		// hold lost while the request stays high: reset drops, rails stay up
		drive(1'b1, 1'b0, 1'b0, 1'b1);
		ticks(28);
		chk({7'h00, resetOut_n}, 8'h01);
		ticks(4);
		chk({7'h00, resetOut_n}, 8'h00);
		chk({2'b00, rails} & 8'h3E, 8'h22);
		// request drops too: shutdown after the full quiet interval
		drive(1'b0, 1'b0, 1'b0, 1'b1);
		ticks(28);
		chk({2'b00, rails} & 8'h3E, 8'h22);
		ticks(4);
		chk({2'b00, rails} & 8'h3E, 8'h06);
		chk({7'h00, resetOut_n}, 8'h00);
	endtask : main_role_test

	// verdict and end of run
	task automatic test_done;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : test_done

	// main sequence
	initial begin
		sub_role_test();
		main_role_test();
		test_done();
	end
endmodule : testbench
